//--- ppl_process_loop.v
// process loop controller computing target output frequency
`default_nettype none
`include "ppl_map.vh"
module ppl_process_loop (
   // clock and reset
   input wire clk,
   input wire rst,
   // frequency command, 0.01 Hz
   input wire [15:0] freqCommand,
   // feedback sources, 0.01 Hz equivalents; analog inputs come from pins
   input wire [15:0] currentAnalogInput,
   input wire [15:0] voltageAnalogInput,
   input wire [15:0] networkFeedback,
   input wire [15:0] pulseTrainInput,
   input wire [15:0] calcFunctionOutput,
   // loop settings
   input wire [1:0] loopEnable,
   input wire [11:0] propGain,
   input wire [15:0] integralTimeSetting,
   input wire [11:0] derivTime,
   input wire [13:0] feedbackScaleFactor,
   input wire [2:0] feedbackSource,
   input wire errorInversionSelect,
   input wire [9:0] loopOutputLimit,
   input wire [1:0] feedForwardSelect,
   // alarm settings
   input wire [15:0] deviationThreshold,
   input wire [15:0] feedbackLowLevel,
   input wire [15:0] feedbackHighLevel,
   // sleep settings
   input wire [15:0] sleepThreshold,
   input wire [7:0] wakeDelay,
   // outputs
   output reg [15:0] targetFreq_q,
   output reg outputRun_q,
   output reg deviationAlarmOutput_q,
   output reg feedbackWindowAlarm_q,
   output reg [31:0] scaledFeedback_q,
   output reg [31:0] scaledSetpoint_q,
   output reg [31:0] scaledTarget_q
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   reg [15:0] curMeta_q, curSync_q, voltMeta_q, voltSync_q;
   always @(posedge clk) begin
      if (rst) begin
         curMeta_q <= 16'h0000;
         curSync_q <= 16'h0000;
         voltMeta_q <= 16'h0000;
         voltSync_q <= 16'h0000;
      end else begin
         curMeta_q <= currentAnalogInput;
         curSync_q <= curMeta_q;
         voltMeta_q <= voltageAnalogInput;
         voltSync_q <= voltMeta_q;
      end
   end

   // ---------------------------------------------------------------
   // sample period divider
   // ---------------------------------------------------------------
   localparam [31:0] SAMPLE_CYC = `PPL_SAMPLE_CYC;
   reg [31:0] divCnt_q;
   reg sampleTick_q;
   always @(posedge clk) begin
      if (rst) begin
         divCnt_q <= 32'h00000000;
         sampleTick_q <= 1'b0;
      end else if (divCnt_q == SAMPLE_CYC - 32'h00000001) begin
         divCnt_q <= 32'h00000000;
         sampleTick_q <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 32'h00000001;
         sampleTick_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // feedback, feed-forward and error
   // ---------------------------------------------------------------
   reg [15:0] feedback;
   always @* begin
      case (feedbackSource)
         `PPL_SRC_VOLT: feedback = voltSync_q;
         `PPL_SRC_NET: feedback = networkFeedback;
         `PPL_SRC_PULSE: feedback = pulseTrainInput;
         `PPL_SRC_CALC: feedback = calcFunctionOutput;
         default: feedback = curSync_q;
      endcase
   end

   reg [15:0] feedFwd;
   always @* begin
      case (feedForwardSelect)
         `PPL_FF_VOLT: feedFwd = voltSync_q;
         `PPL_FF_CUR: feedFwd = curSync_q;
         default: feedFwd = 16'h0000;
      endcase
   end

   wire signed [17:0] rawErr = $signed({2'b00, freqCommand}) - $signed({2'b00, feedback});
   wire signed [17:0] loopErr = errorInversionSelect ? -rawErr : rawErr;
   wire [17:0] devMag = rawErr[17] ? -rawErr : rawErr;

   // ---------------------------------------------------------------
   // loop terms
   // ---------------------------------------------------------------
   // gains clamp to their documented ceilings
   wire [11:0] kp = (propGain > `PPL_KP_MAX) ? `PPL_KP_MAX : propGain;
   wire [15:0] ti = (integralTimeSetting > `PPL_TI_MAX) ? `PPL_TI_MAX : integralTimeSetting;
   wire [11:0] td = (derivTime > `PPL_TD_MAX) ? `PPL_TD_MAX : derivTime;
   wire [9:0] lim = (loopOutputLimit > `PPL_LIM_MAX) ? `PPL_LIM_MAX : loopOutputLimit;

   reg signed [47:0] integ_q;
   reg signed [17:0] prevErr_q;
   reg signed [47:0] pidSum_q;

   wire signed [31:0] pTerm = ($signed({{14{loopErr[17]}}, loopErr}) * $signed({20'h00000, kp})) / 32'sd100;
   // integrator step: err * 1000 / (ti tenths-of-seconds * samples per second / 10)
   wire signed [47:0] iDen = $signed({32'h00000000, ti}) * $signed({32'h00000000, `PPL_TENTH_SAMPLES});
   wire signed [47:0] iNext = integ_q + $signed({{30{loopErr[17]}}, loopErr});
   wire signed [47:0] iTerm = (ti == 16'h0000) ? 48'sd0 : (integ_q * 48'sd1000) / iDen;
   // derivative: td tenths of s times error change per sample, times 100
   wire signed [18:0] dErr = $signed({loopErr[17], loopErr}) - $signed({prevErr_q[17], prevErr_q});
   wire signed [47:0] dTerm = ($signed({{29{dErr[18]}}, dErr}) * $signed({36'h000000000, td}) * 48'sd100);
   wire signed [47:0] pidNext = $signed({{16{pTerm[31]}}, pTerm}) + iTerm + dTerm
      + $signed({32'h00000000, feedFwd});

   always @(posedge clk) begin
      if (rst || loopEnable == `PPL_EN_OFF) begin
         integ_q <= 48'sd0;
         prevErr_q <= 18'sd0;
         pidSum_q <= 48'sd0;
      end else if (sampleTick_q) begin
         prevErr_q <= loopErr;
         integ_q <= (ti == 16'h0000) ? 48'sd0 : iNext;
         pidSum_q <= pidNext;
      end
   end

   // ---------------------------------------------------------------
   // output limit and mode selection
   // ---------------------------------------------------------------
   // band in 0.01 Hz: lim (0.1 %) of full scale
   wire [31:0] band = ({22'h000000, lim} * {16'h0000, `PPL_FULL_SCALE}) / 32'd1000;
   wire signed [47:0] signedOut = (loopEnable == `PPL_EN_REV) ? -pidSum_q : pidSum_q;
   wire signed [47:0] spWide = $signed({32'h00000000, freqCommand});
   wire signed [47:0] bandWide = $signed({16'h0000, band});
   reg signed [47:0] limited;
   always @* begin
      if (lim == 10'h000) begin
         limited = signedOut;
      end else if (signedOut > spWide + bandWide) begin
         limited = spWide + bandWide;
      end else if (signedOut < spWide - bandWide) begin
         limited = spWide - bandWide;
      end else begin
         limited = signedOut;
      end
   end
   wire [15:0] loopFreq = (limited < 48'sd0) ? 16'h0000 :
      (limited > 48'sd65535) ? 16'hFFFF : limited[15:0];

   // loop result replaces command when enabled
   wire [15:0] demand = (loopEnable == `PPL_EN_OFF) ? freqCommand : loopFreq;

   // ---------------------------------------------------------------
   // sleep and wake
   // ---------------------------------------------------------------
   wire sleeping;
   // supervisor watches demand in every mode
   ppl_sleep_ctrl uSleep (
      .clk(clk),
      .rst(rst),
      .sampleTick(sampleTick_q),
      .watchValue(demand),
      .sleepThreshold(sleepThreshold),
      .wakeDelay(wakeDelay),
      .sleeping_q(sleeping)
   );

   // ---------------------------------------------------------------
   // outputs, alarms and scaled monitors
   // ---------------------------------------------------------------
   wire [13:0] scale = (feedbackScaleFactor < `PPL_SCALE_MIN) ? `PPL_SCALE_MIN :
      (feedbackScaleFactor > `PPL_SCALE_MAX) ? `PPL_SCALE_MAX : feedbackScaleFactor;
   always @(posedge clk) begin
      if (rst) begin
         targetFreq_q <= 16'h0000;
         outputRun_q <= 1'b0;
         deviationAlarmOutput_q <= 1'b0;
         feedbackWindowAlarm_q <= 1'b0;
         scaledFeedback_q <= 32'h00000000;
         scaledSetpoint_q <= 32'h00000000;
         scaledTarget_q <= 32'h00000000;
      end else begin
         targetFreq_q <= sleeping ? 16'h0000 : demand;
         outputRun_q <= ~sleeping;
         deviationAlarmOutput_q <= (loopEnable != `PPL_EN_OFF) && (devMag > {2'b00, deviationThreshold});
         feedbackWindowAlarm_q <= (feedback < feedbackLowLevel) || (feedback > feedbackHighLevel);
         scaledFeedback_q <= {2'b00, scale} * {16'h0000, feedback};
         scaledSetpoint_q <= {2'b00, scale} * {16'h0000, freqCommand};
         scaledTarget_q <= {2'b00, scale} * {16'h0000, demand};
      end
   end
endmodule // ppl_process_loop
`default_nettype wire

//--- ppl_map.vh
// constants and field codes for the process loop controller
//
// Function
// - with loop enabled, command is setpoint and loop calculation drives target frequency
// - enable select: disabled (default), enabled, enabled with reversed output sign
// - proportional gain 0.00..25.00 scales error for proportional term
// - integral time 0.0..3600 s; gain is reciprocal; zero disables integrator
// - derivative time 0.0..100 s weights rate of change of error
// - monitored values multiplied by scale factor 0.01..99.99
// - feedback source: current, voltage, network, pulse train, calculated; current default
// - error is setpoint minus feedback or its negation
// - output limit 0.0..100.0 percent bounds setpoint minus output; linear inside
// - output adjusted so setpoint minus output never exceeds a nonzero limit; a zero limit leaves output unbounded
// - feed-forward: none (default), voltage input, current input
// - deviation alarm when loop enabled and deviation exceeds its threshold
// - feedback window alarm when feedback outside lower..upper levels
// - output stops when loop output or command falls below sleep threshold 0..400.0 Hz
// - restart after value stays above threshold for delay 0..25.5 s
// - sleep and wake active whether loop enabled or not
`ifndef PPL_MAP_VH
`define PPL_MAP_VH
// enable modes
`define PPL_EN_OFF 2'h0
`define PPL_EN_ON 2'h1
`define PPL_EN_REV 2'h2
// feedback sources
`define PPL_SRC_CUR 3'h0
`define PPL_SRC_VOLT 3'h1
`define PPL_SRC_NET 3'h2
`define PPL_SRC_PULSE 3'h3
`define PPL_SRC_CALC 3'h4
// feed-forward sources
`define PPL_FF_NONE 2'h0
`define PPL_FF_VOLT 2'h1
`define PPL_FF_CUR 2'h2
// setting limits: gain x100, times x10, scale x100, limit x10, freq x100 Hz
`define PPL_KP_MAX 12'h9C4
`define PPL_TI_MAX 16'h8CA0
`define PPL_TD_MAX 12'h3E8
`define PPL_SCALE_MIN 14'h0001
`define PPL_SCALE_MAX 14'h270F
`define PPL_LIM_MAX 10'h3E8
`define PPL_SLEEP_MAX 16'h9C40
`define PPL_DELAY_MAX 8'hFF
// full scale of frequency values, 0.01 Hz units
`define PPL_FULL_SCALE 16'h9C40
// timing: clock 100 MHz, sample period 1 ms, delay unit 0.1 s
`define PPL_CLK_HZ 100000000
`define PPL_SAMPLE_US 1000
`define PPL_SAMPLE_CYC ((`PPL_CLK_HZ / 1000000) * `PPL_SAMPLE_US)
`define PPL_SAMPLES_PER_SEC 16'h03E8
`define PPL_TENTH_SAMPLES 16'h0064
`endif

//--- ppl_sleep_ctrl.v
// sleep and wake supervisor for the drive output
`default_nettype none
`include "ppl_map.vh"
module ppl_sleep_ctrl (
   // clock and reset
   input wire clk,
   input wire rst,
   // sample tick and monitored value
   input wire sampleTick,
   input wire [15:0] watchValue,
   // settings
   input wire [15:0] sleepThreshold,
   input wire [7:0] wakeDelay,
   // state
   output reg sleeping_q
);
   reg [15:0] tenthCnt_q;
   reg [7:0] delayCnt_q;
   wire [15:0] thr = (sleepThreshold > `PPL_SLEEP_MAX) ? `PPL_SLEEP_MAX : sleepThreshold;
   wire tenthDone = (tenthCnt_q == `PPL_TENTH_SAMPLES - 16'h0001);

   always @(posedge clk) begin
      if (rst) begin
         sleeping_q <= 1'b0;
         tenthCnt_q <= 16'h0000;
         delayCnt_q <= 8'h00;
      end else if (sampleTick) begin
         if (!sleeping_q) begin
            tenthCnt_q <= 16'h0000;
            delayCnt_q <= 8'h00;
            if (watchValue < thr) begin
               sleeping_q <= 1'b1;
            end
         end else if (watchValue <= thr) begin
            tenthCnt_q <= 16'h0000;
            delayCnt_q <= 8'h00;
         end else if (delayCnt_q >= wakeDelay) begin
            sleeping_q <= 1'b0;
         end else if (tenthDone) begin
            tenthCnt_q <= 16'h0000;
            delayCnt_q <= delayCnt_q + 8'h01;
         end else begin
            tenthCnt_q <= tenthCnt_q + 16'h0001;
         end
      end
   end
endmodule // ppl_sleep_ctrl
`default_nettype wire

//--- ppl_assertions.sv
// concurrent checks on the process loop controller ports
`default_nettype none
module ppl_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] freqCommand, networkFeedback, deviationThreshold,
   input wire logic [15:0] feedbackLowLevel, feedbackHighLevel, sleepThreshold,
   input wire logic [1:0] loopEnable,
   input wire logic [2:0] feedbackSource,
   input wire logic [13:0] feedbackScaleFactor,
   input wire logic [15:0] targetFreq_q,
   input wire logic outputRun_q, deviationAlarmOutput_q, feedbackWindowAlarm_q,
   input wire logic [31:0] scaledFeedback_q, scaledSetpoint_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] err;
   logic netSel, outside, scaleOk;
   assign err = (freqCommand > networkFeedback) ? freqCommand - networkFeedback : networkFeedback - freqCommand;
   assign netSel = feedbackSource == 3'h2;
   assign outside = networkFeedback < feedbackLowLevel || networkFeedback > feedbackHighLevel;
   // out-of-range factors are clamped by the design, so only in-range ones are compared
   assign scaleOk = feedbackScaleFactor != 14'h0 && feedbackScaleFactor <= 14'h270F;
   a_cmd_follow: assert property (
      loopEnable == 2'h0 ##1 outputRun_q |-> targetFreq_q == $past(freqCommand)) else $error("command not passed");
   a_sleep_zero: assert property (
      !outputRun_q |-> targetFreq_q == 16'h0) else $error("output live while asleep");
   // sleep state is taken on the sample tick two edges before the run flag falls
   a_sleep_entry: assert property (
      $fell(outputRun_q) |-> $past(loopEnable, 2) != 2'h0 || $past(freqCommand, 2) < $past(sleepThreshold, 2))
      else $error("sleep without low command");
   a_dev_quiet: assert property (
      loopEnable == 2'h0 |=> !deviationAlarmOutput_q) else $error("deviation alarm with loop off");
   a_dev_raise: assert property (
      loopEnable != 2'h0 && netSel && err > deviationThreshold |=> deviationAlarmOutput_q) else $error("no dev alarm");
   a_dev_clear: assert property (
      loopEnable != 2'h0 && netSel && err <= deviationThreshold |=> !deviationAlarmOutput_q) else $error("dev alarm");
   a_win_out: assert property (
      netSel && outside |=> feedbackWindowAlarm_q) else $error("window alarm missing");
   a_win_in: assert property (
      netSel && !outside |=> !feedbackWindowAlarm_q) else $error("window alarm spurious");
   a_scale_fb: assert property (
      netSel && scaleOk |=> scaledFeedback_q == $past(networkFeedback) * $past(feedbackScaleFactor))
      else $error("bad scaled pv");
   a_scale_sp: assert property (
      scaleOk |=> scaledSetpoint_q == $past(freqCommand) * $past(feedbackScaleFactor))
      else $error("bad scaled setpoint");
   c_sleep: cover property ($fell(outputRun_q));
   c_dev: cover property ($rose(deviationAlarmOutput_q));
   c_win: cover property ($rose(feedbackWindowAlarm_q));
endmodule // ppl_assertions
`default_nettype wire

//--- ppl_sensor_model.sv
// process sensor model feeding the five feedback sources
`default_nettype none
module ppl_sensor_model (
   input wire logic clk,
   input wire logic [2:0] srcSel,
   input wire logic [15:0] pv,
   output wire logic [15:0] currentAnalogInput, voltageAnalogInput, networkFeedback,
   output wire logic [15:0] pulseTrainInput, calcFunctionOutput
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] idle_q = 16'h5A5A;
   // unwired sources flip between two values every cycle so a value one cycle stale can never pass
   always @(posedge clk) idle_q <= ~idle_q + 16'h1;
   assign currentAnalogInput = srcSel == 3'h0 ? pv : idle_q;
   assign voltageAnalogInput = srcSel == 3'h1 ? pv : idle_q;
   assign networkFeedback = srcSel == 3'h2 ? pv : idle_q;
   assign pulseTrainInput = srcSel == 3'h3 ? pv : idle_q;
   assign calcFunctionOutput = srcSel == 3'h4 ? pv : idle_q;
endmodule // ppl_sensor_model
`default_nettype wire

//--- ppl_process_loop_test.sv
// self-checking bench for the process loop controller
`default_nettype none
`include "ppl_map.vh"
module ppl_process_loop_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int kind; logic [31:0] val; time due;} ppl_note_t;
   logic clk = 1'b0, rst = 1'b1, errorInversionSelect = 1'b0;
   logic [15:0] freqCommand = 16'h0, pv = 16'h0, sleepThreshold = 16'h0, deviationThreshold = 16'h0;
   logic [15:0] feedbackLowLevel = 16'h0, feedbackHighLevel = 16'hFFFF, integralTimeSetting = 16'h0;
   logic [11:0] propGain = 12'h64, derivTime = 12'h0;
   logic [13:0] feedbackScaleFactor = 14'h64;
   logic [9:0] loopOutputLimit = 10'h0;
   logic [7:0] wakeDelay = 8'h0;
   logic [2:0] feedbackSource = 3'h2;
   logic [1:0] loopEnable = 2'h0, feedForwardSelect = 2'h0;
   wire logic [15:0] currentAnalogInput, voltageAnalogInput, networkFeedback, pulseTrainInput, calcFunctionOutput;
   wire logic [15:0] targetFreq_q;
   wire logic outputRun_q, deviationAlarmOutput_q, feedbackWindowAlarm_q;
   wire logic [31:0] scaledFeedback_q, scaledSetpoint_q, scaledTarget_q;
   ppl_note_t expQ[$];
   int fails = 0, n_tests = 0, cyc = 0;
   integer seed = 32'hF4F448DA;
   always #5 clk = ~clk;
   ppl_process_loop dut_u (.*);
   ppl_sensor_model sens_u (.*, .srcSel(feedbackSource));
   task automatic print_verdict;
      // a note still queued at the end was never looked at
      fails += expQ.size();
      $display("checks=%0d fails=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic note(int kind, logic [31:0] val, int lat);
      expQ.push_back('{kind, val, $time + 10 * lat});
   endtask
   task automatic hold(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic cmpWord(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpBit(logic got, logic exp);
      cmpWord({31'h0, got}, {31'h0, exp});
   endtask
   // outputs settle long before the falling edge, so results are taken there
   always @(negedge clk) begin
      while (expQ.size() > 0 && expQ[0].due <= $time) begin
         case (expQ[0].kind)
            0: cmpWord({16'h0, targetFreq_q}, expQ[0].val);
            1: cmpBit(outputRun_q, expQ[0].val[0]);
            2: cmpBit(deviationAlarmOutput_q, expQ[0].val[0]);
            3: cmpBit(feedbackWindowAlarm_q, expQ[0].val[0]);
            4: cmpWord(scaledFeedback_q, expQ[0].val);
            5: cmpWord(scaledSetpoint_q, expQ[0].val);
            default: cmpWord(scaledTarget_q, expQ[0].val);
         endcase
         void'(expQ.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 120000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      int v, lat, b;
      logic [15:0] e;
      hold(20);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         freqCommand = v[15:0];
         feedbackScaleFactor = v[29:16] % 14'h270F + 14'h1;
         note(0, freqCommand, 1);
         note(1, 1, 1);
         note(5, freqCommand * feedbackScaleFactor, 1);
         note(6, freqCommand * feedbackScaleFactor, 1);
         hold(1);
      end
      for (int i = 0; i < 15; i++) begin
         v = $random(seed);
         feedbackSource = 3'(i % 5);
         feedbackLowLevel = v[31:16] & 16'h7FFF;
         feedbackHighLevel = feedbackLowLevel + 16'h4000;
         pv = (i == 14) ? feedbackHighLevel : v[15:0];
         // analog sources pass a two-flop synchroniser first
         lat = (feedbackSource < 3'h2) ? 3 : 1;
         note(3, pv < feedbackLowLevel || pv > feedbackHighLevel, lat);
         note(4, pv * feedbackScaleFactor, lat);
         hold(lat);
      end
      feedbackSource = 3'h2;
      for (int i = 0; i < 12; i++) begin
         v = $random(seed);
         loopEnable = 2'(i % 3);
         errorInversionSelect = i >= 6;
         propGain = v[11:0] % 12'h9C5;
         integralTimeSetting = v[31:16] % 16'h8CA1;
         derivTime = v[27:16] % 12'h3E9;
         loopOutputLimit = v[25:16] % 10'h3E9;
         feedForwardSelect = v[1:0] % 2'h3;
         pv = v[15:0];
         e = (freqCommand > pv) ? freqCommand - pv : pv - freqCommand;
         deviationThreshold = (i == 11) ? e : v[31:16] >> 1;
         note(2, loopEnable != 2'h0 && e > deviationThreshold, 1);
         // loop sum is still zero before the first sample, so only the band moves the output
         b = loopOutputLimit * `PPL_FULL_SCALE / 1000;
         note(0, (loopEnable == 2'h0) ? freqCommand : (b != 0 && freqCommand > b) ? freqCommand - b : 0, 1);
         hold(1);
      end
      loopEnable = 2'h0;
      sleepThreshold = 16'h03E8;
      wakeDelay = 8'h1;
      freqCommand = 16'h01F4;
      note(0, 16'h01F4, 1);
      hold(1);
      for (lat = 0; lat < 100500 && outputRun_q !== 1'b0; lat++) begin
         hold(1);
      end
      note(0, 0, 1);
      note(1, 0, 1);
      hold(1);
      // command back above threshold must not wake before the delay
      freqCommand = 16'h07D0;
      note(1, 0, 50);
      note(0, 0, 50);
      // one cycle beyond the last due note so it is compared before the end
      hold(51);
      print_verdict();
   end
endmodule // ppl_process_loop_test
bind ppl_process_loop ppl_assertions chk_u (.*);
`default_nettype wire
